// [design/daf_host.sv]
// controller end: axi4-lite command registers driving the serial link
module daf_host #(
  parameter int HALF = daf_pkg::SCLK_HALF_CYCLES
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [3:0] s_axi_awaddr,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output logic [1:0] s_axi_bresp,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire logic [3:0] s_axi_araddr,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  daf_link_if.host link
);
  typedef enum logic [1:0] {DAFH_IDLE = 2'b00, DAFH_SHIFT = 2'b01} dafh_state_type;

  // pin synchronisers: bit0 sdo, bit1 fault
  logic [1:0] s1, s2, s3, lvl, next_lvl;
  always_comb begin
    next_lvl = (lvl & ~(s2 ~^ s3)) | (s3 & (s2 ~^ s3));
  end
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      s1 <= 2'h0;
      s2 <= 2'h0;
      s3 <= 2'h0;
      lvl <= 2'h0;
    end else begin
      s1 <= {link.fault_alert, link.sdo};
      s2 <= s1;
      s3 <= s2;
      lvl <= next_lvl;
    end
  end

  // axi4-lite slave and link state
  dafh_state_type state, next_state;
  logic aw_held, next_aw_held, w_held, next_w_held, bvalid, next_bvalid, rvalid, next_rvalid;
  logic [3:0] awaddr, next_awaddr;
  logic [31:0] wdata, next_wdata, rdata, next_rdata;
  logic [3:0] wstrb, next_wstrb;
  logic [1:0] bresp, next_bresp, rresp, next_rresp;
  logic [7:0] div, next_div;
  logic [5:0] cnt, next_cnt, nbits, next_nbits;
  logic [31:0] tx, next_tx, rx, next_rx;
  logic [23:0] rx_data, next_rx_data;
  logic crc_ok, next_crc_ok, sclk, next_sclk, sync_n, next_sync_n, sdi, next_sdi;
  logic [31:0] rx_shifted;
  logic busy;

  assign busy = (state != DAFH_IDLE);
  assign s_axi_awready = !aw_held && !bvalid;
  assign s_axi_wready = !w_held && !bvalid;
  assign s_axi_arready = !rvalid;
  assign s_axi_bvalid = bvalid;
  assign s_axi_bresp = bresp;
  assign s_axi_rvalid = rvalid;
  assign s_axi_rdata = rdata;
  assign s_axi_rresp = rresp;
  assign link.sclk = sclk;
  assign link.sync_n = sync_n;
  assign link.sdi = sdi;

  always_comb begin
    next_state = state;
    next_aw_held = aw_held;
    next_w_held = w_held;
    next_awaddr = awaddr;
    next_wdata = wdata;
    next_wstrb = wstrb;
    next_bvalid = bvalid;
    next_bresp = bresp;
    next_rvalid = rvalid;
    next_rdata = rdata;
    next_rresp = rresp;
    next_div = div;
    next_cnt = cnt;
    next_nbits = nbits;
    next_tx = tx;
    next_rx = rx;
    next_rx_data = rx_data;
    next_crc_ok = crc_ok;
    next_sclk = sclk;
    next_sync_n = sync_n;
    next_sdi = sdi;
    rx_shifted = {rx[30:0], lvl[0]};
    if (s_axi_awvalid && s_axi_awready) begin
      next_aw_held = 1'b1;
      next_awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_w_held = 1'b1;
      next_wdata = s_axi_wdata;
      next_wstrb = s_axi_wstrb;
    end
    if (bvalid && s_axi_bready) begin
      next_bvalid = 1'b0;
    end
    if (rvalid && s_axi_rready) begin
      next_rvalid = 1'b0;
    end
    if (s_axi_arvalid && !rvalid) begin
      next_rvalid = 1'b1;
      next_rresp = daf_pkg::RESP_OKAY;
      next_rdata = 32'h0000_0000;
      case (s_axi_araddr)
        daf_pkg::HREG_STATUS: begin
          next_rdata[daf_pkg::STAT_BUSY] = busy;
          next_rdata[daf_pkg::STAT_FAULT] = lvl[1]; // R2
          next_rdata[daf_pkg::STAT_CRC_OK] = crc_ok;
        end
        daf_pkg::HREG_RX: next_rdata = {8'h00, rx_data};
        daf_pkg::HREG_CMD: next_rdata = 32'h0000_0000;
        default: next_rresp = daf_pkg::RESP_DECERR;
      endcase
    end
    case (state)
      DAFH_IDLE: begin
        // hold sync_n high a half period so the far end sees the frame end
        if (div != 8'(HALF - 1)) begin
          next_div = div + 8'h01;
        end
        if (aw_held && w_held && !bvalid && (div == 8'(HALF - 1))) begin
          next_aw_held = 1'b0;
          next_w_held = 1'b0;
          next_bvalid = 1'b1;
          next_bresp = daf_pkg::RESP_OKAY;
          if (awaddr != daf_pkg::HREG_CMD) begin
            next_bresp = daf_pkg::RESP_DECERR;
          end else if (&wstrb) begin
            next_state = DAFH_SHIFT;
            if (wdata[daf_pkg::HCMD_LONG_BIT]) begin
              next_tx = {wdata[23:0], daf_pkg::crc8_24(wdata[23:0])}; // R6 R7 R16
              next_nbits = 6'(daf_pkg::FRAME_LONG); // R8
            end else begin
              next_tx = {wdata[23:0], 8'h00};
              next_nbits = 6'(daf_pkg::FRAME_SHORT);
            end
            next_sync_n = 1'b0;
            next_sdi = wdata[23];
            next_div = 8'h00;
            next_cnt = 6'h00;
            next_sclk = 1'b0;
          end
        end
      end
      DAFH_SHIFT: begin
        next_div = div + 8'h01;
        if (div == 8'(HALF - 1)) begin
          next_div = 8'h00;
          next_sclk = !sclk;
          if (!sclk) begin
            next_cnt = cnt + 6'h01;
          end else begin
            next_rx = rx_shifted;
            if (cnt == nbits) begin
              next_sync_n = 1'b1; // R8
              next_state = DAFH_IDLE;
              if (nbits == 6'(daf_pkg::FRAME_LONG)) begin
                next_rx_data = rx_shifted[31:8];
                next_crc_ok = (daf_pkg::crc8_24(rx_shifted[31:8]) == rx_shifted[7:0]); // R12
              end else begin
                next_rx_data = rx_shifted[23:0];
                next_crc_ok = 1'b1;
              end
            end else begin
              next_tx = {tx[30:0], 1'b0};
              next_sdi = tx[30];
            end
          end
        end
      end
      default: next_state = DAFH_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      state <= DAFH_IDLE;
      aw_held <= 1'b0;
      w_held <= 1'b0;
      awaddr <= 4'h0;
      wdata <= 32'h0000_0000;
      wstrb <= 4'h0;
      bvalid <= 1'b0;
      bresp <= daf_pkg::RESP_OKAY;
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= daf_pkg::RESP_OKAY;
      div <= 8'h00;
      cnt <= 6'h00;
      nbits <= 6'h00;
      tx <= 32'h0000_0000;
      rx <= 32'h0000_0000;
      rx_data <= 24'h00_0000;
      crc_ok <= 1'b0;
      sclk <= 1'b0;
      sync_n <= 1'b1;
      sdi <= 1'b0;
    end else begin
      state <= next_state;
      aw_held <= next_aw_held;
      w_held <= next_w_held;
      awaddr <= next_awaddr;
      wdata <= next_wdata;
      wstrb <= next_wstrb;
      bvalid <= next_bvalid;
      bresp <= next_bresp;
      rvalid <= next_rvalid;
      rdata <= next_rdata;
      rresp <= next_rresp;
      div <= next_div;
      cnt <= next_cnt;
      nbits <= next_nbits;
      tx <= next_tx;
      rx <= next_rx;
      rx_data <= next_rx_data;
      crc_ok <= next_crc_ok;
      sclk <= next_sclk;
      sync_n <= next_sync_n;
      sdi <= next_sdi;
    end
  end
endmodule : daf_host

// [include/daf_pkg.sv]
// shared constants, field layout and frame check function for the fault-alert link
package daf_pkg;
  localparam int FRAME_SHORT = 24;
  localparam int FRAME_LONG = 32;
  localparam logic [7:0] CRC_POLY = 8'h07;
  localparam logic [7:0] CRC_INIT = 8'h00;
  // command byte: bit 7 read, bits 6:0 register address
  localparam int CMD_RD_POS = 7;
  localparam logic [6:0] ADDR_DAC = 7'h01;
  localparam logic [6:0] ADDR_CTRL = 7'h02;
  localparam logic [6:0] ADDR_FAULT = 7'h05;
  localparam logic [7:0] CMD_START_CONV = 8'h08;
  // control register fields
  localparam int CTRL_WDT_SEL_LSB = 0;
  localparam int CTRL_WDT_EN_BIT = 3;
  localparam logic [15:0] CTRL_RESET = 16'h0008;
  localparam logic [15:0] DAC_RESET = 16'h0000;
  // fault register fields
  localparam int FLT_COMM = 15;
  localparam int FLT_FCE = 14;
  localparam int FLT_OVER = 13;
  localparam int FLT_UNDER = 12;
  // alarm codes: upscale 22.8 mA/24 mA, downscale 3.2 mA
  localparam logic [15:0] ALARM_UP_CODE = 16'hFFFF;
  localparam logic [15:0] ALARM_DOWN_CODE = 16'h0000;
  // loop current tolerance 0.01 % of full scale, in basis points
  localparam int CUR_TOL_BP = 1;
  localparam logic [16:0] CUR_TOL_CODES = 17'((65536 * CUR_TOL_BP) / 10000);
  // timing
  localparam int CLK_HZ = 40_000_000;
  localparam int WDT_UNIT_MS = 50;
  localparam int WDT_UNIT_CYCLES = (CLK_HZ / 1000) * WDT_UNIT_MS;
  localparam int SCLK_HALF_CYCLES = 8;
  // host register map
  localparam logic [3:0] HREG_CMD = 4'h0;
  localparam logic [3:0] HREG_STATUS = 4'h4;
  localparam logic [3:0] HREG_RX = 4'h8;
  localparam int HCMD_LONG_BIT = 31;
  localparam int STAT_BUSY = 0;
  localparam int STAT_FAULT = 1;
  localparam int STAT_CRC_OK = 2;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  // msb first, zero start, no final inversion
  function automatic logic [7:0] crc8_24(input logic [23:0] d);
    logic [7:0] c;
    logic fb;
    c = CRC_INIT;
    for (int i = 23; i >= 0; i--) begin
      fb = c[7] ^ d[i];
      c = {c[6:0], 1'b0} ^ (fb ? CRC_POLY : 8'h00);
    end
    return c;
  endfunction : crc8_24
endpackage : daf_pkg

// [include/daf_link_if.sv]
// serial link between controller and converter, with fault alert line
interface daf_link_if;
  logic sclk;
  logic sync_n;
  logic sdi;
  logic sdo;
  logic fault_alert;
  modport dev (input sclk, input sync_n, input sdi, output sdo, output fault_alert);
  modport host (output sclk, output sync_n, output sdi, input sdo, input fault_alert);
endinterface : daf_link_if

// [design/daf_dev.sv]
// converter end: frame receive and check, watchdog alarm, loop current flags, fault alert
// Function
// R1 - every fault raises alert and sets register flag
// R2 - controller reads fault register on alert high (host does not read it itself, only reports alert in status bit 1)
// R3 - no valid access past timeout raises comm fault
// R4 - comm fault forces loop current to alarm
// R5 - alarm direction input picks upscale or downscale
// R6 - 32-bit write frames carry check byte last
// R7 - check byte uses x^8+x^2+x+1 crc
// R8 - all 32 bits shifted before sync rises
// R9 - matching check byte: frame data applied
// R10 - mismatch: alert and frame check error flag
// R11 - fault register read clears frame check error
// R12 - 32-bit readback appends check byte to 24
// R13 - loop current off by over 0.01% flags fault
// R14 - under and over current flags by direction
// R15 - command 0x08 starts conversion, fault read returns
// R16 - crc msb first, zero start, no inversion
module daf_dev #(
  parameter int unsigned WDT_UNIT = daf_pkg::WDT_UNIT_CYCLES
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  daf_link_if.dev link,
  input wire logic alarm_up,
  input wire logic [15:0] meas_code,
  input wire logic [7:0] adc_code,
  output logic [15:0] loop_code,
  output logic alarm_active,
  output logic conv_start
);
  // pin synchronisers: bit0 sclk, bit1 sync_n, bit2 sdi
  logic [2:0] s1, s2, s3, lvl, next_lvl;
  logic sclk_rise, sclk_fall, sync_rise, sync_fall;
  always_comb begin
    next_lvl = (lvl & ~(s2 ~^ s3)) | (s3 & (s2 ~^ s3));
    sclk_rise = !lvl[0] && next_lvl[0] && !lvl[1];
    sclk_fall = lvl[0] && !next_lvl[0] && !lvl[1];
    sync_fall = lvl[1] && !next_lvl[1];
    sync_rise = !lvl[1] && next_lvl[1];
  end
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      s1 <= 3'h2;
      s2 <= 3'h2;
      s3 <= 3'h2;
      lvl <= 3'h2;
    end else begin
      s1 <= {link.sdi, link.sync_n, link.sclk};
      s2 <= s1;
      s3 <= s2;
      lvl <= next_lvl;
    end
  end

  // alarm direction pin synchroniser
  logic [2:0] dir_sync, next_dir_sync;
  logic dir_up, next_dir_up;
  always_comb begin
    next_dir_sync = {dir_sync[1:0], alarm_up};
    next_dir_up = (dir_sync[2] == dir_sync[1]) ? dir_sync[2] : dir_up;
  end
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      dir_sync <= 3'h7;
      dir_up <= 1'b1;
    end else begin
      dir_sync <= next_dir_sync;
      dir_up <= next_dir_up;
    end
  end

  // frame, registers, watchdog and fault state
  logic [31:0] rx, next_rx, tx, next_tx, wdt_cnt, next_wdt_cnt, wdt_limit;
  logic [5:0] cnt, next_cnt;
  logic [15:0] dac_reg, next_dac_reg, ctrl_reg, next_ctrl_reg, next_loop_code, fault_reg, rd_val;
  logic fce, next_fce, comm, next_comm, over, next_over, under, next_under;
  logic alert, next_alert, next_conv_start, next_alarm_active;
  logic long_frame, frame_ok, valid;
  logic [23:0] payload;
  logic [7:0] cmd;
  logic [16:0] prog17, meas17;

  assign link.sdo = tx[31];
  assign link.fault_alert = alert;

  always_comb begin
    next_rx = rx;
    next_tx = tx;
    next_cnt = cnt;
    next_dac_reg = dac_reg;
    next_ctrl_reg = ctrl_reg;
    next_fce = fce;
    next_conv_start = 1'b0;
    long_frame = (cnt == 6'(daf_pkg::FRAME_LONG));
    payload = long_frame ? rx[31:8] : rx[23:0]; // R6
    cmd = payload[23:16];
    frame_ok = 1'b0;
    valid = 1'b0;
    fault_reg = 16'h0000;
    fault_reg[daf_pkg::FLT_COMM] = comm;
    fault_reg[daf_pkg::FLT_FCE] = fce;
    fault_reg[daf_pkg::FLT_OVER] = over;
    fault_reg[daf_pkg::FLT_UNDER] = under;
    fault_reg[7:0] = adc_code; // R15
    case (cmd[6:0])
      daf_pkg::ADDR_DAC: rd_val = dac_reg;
      daf_pkg::ADDR_CTRL: rd_val = ctrl_reg;
      daf_pkg::ADDR_FAULT: rd_val = fault_reg;
      default: rd_val = 16'h0000;
    endcase
    if (sync_fall) begin
      next_cnt = 6'h00;
    end
    if (sclk_rise) begin
      next_rx = {rx[30:0], next_lvl[2]};
      if (cnt != 6'h3F) begin
        next_cnt = cnt + 6'h01;
      end
    end
    if (sclk_fall) begin
      next_tx = {tx[30:0], 1'b0};
    end
    if (sync_rise) begin
      if (long_frame) begin
        frame_ok = (daf_pkg::crc8_24(payload) == rx[7:0]); // R7 R16
      end else begin
        frame_ok = (cnt == 6'(daf_pkg::FRAME_SHORT));
      end
      valid = frame_ok;
    end
    if (valid) begin // R9
      if (cmd == daf_pkg::CMD_START_CONV) begin
        next_conv_start = 1'b1; // R15
      end else if (cmd[daf_pkg::CMD_RD_POS]) begin
        if (long_frame) begin
          next_tx = {cmd, rd_val, daf_pkg::crc8_24({cmd, rd_val})}; // R12
        end else begin
          next_tx = {cmd, rd_val, 8'h00};
        end
        if (cmd[6:0] == daf_pkg::ADDR_FAULT) begin
          next_fce = 1'b0; // R11
        end
      end else if (cmd[6:0] == daf_pkg::ADDR_DAC) begin
        next_dac_reg = payload[15:0];
      end else if (cmd[6:0] == daf_pkg::ADDR_CTRL) begin
        next_ctrl_reg = payload[15:0];
      end
    end
    if (sync_rise && long_frame && !frame_ok) begin
      next_fce = 1'b1; // R10
    end
  end

  // watchdog, alarm substitution and loop current compare
  always_comb begin
    wdt_limit = 32'((32'(ctrl_reg[daf_pkg::CTRL_WDT_SEL_LSB +: 3]) + 32'd1) * WDT_UNIT);
    next_wdt_cnt = wdt_cnt;
    if (valid || !ctrl_reg[daf_pkg::CTRL_WDT_EN_BIT]) begin
      next_wdt_cnt = 32'h0000_0000;
    end else if (wdt_cnt < wdt_limit) begin
      next_wdt_cnt = wdt_cnt + 32'd1;
    end
    next_comm = ctrl_reg[daf_pkg::CTRL_WDT_EN_BIT] && !valid && (wdt_cnt >= wdt_limit); // R3
    next_alarm_active = next_comm;
    if (comm) begin
      next_loop_code = dir_up ? daf_pkg::ALARM_UP_CODE : daf_pkg::ALARM_DOWN_CODE; // R4 R5
    end else begin
      next_loop_code = dac_reg;
    end
    prog17 = {1'b0, loop_code};
    meas17 = {1'b0, meas_code};
    next_over = meas17 > (prog17 + daf_pkg::CUR_TOL_CODES); // R13 R14
    next_under = (meas17 + daf_pkg::CUR_TOL_CODES) < prog17; // R13 R14
    next_alert = next_comm || next_fce || next_over || next_under; // R1
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      rx <= 32'h0000_0000;
      tx <= 32'h0000_0000;
      cnt <= 6'h00;
      dac_reg <= daf_pkg::DAC_RESET;
      ctrl_reg <= daf_pkg::CTRL_RESET;
      fce <= 1'b0;
      comm <= 1'b0;
      over <= 1'b0;
      under <= 1'b0;
      alert <= 1'b0;
      wdt_cnt <= 32'h0000_0000;
      loop_code <= daf_pkg::DAC_RESET;
      alarm_active <= 1'b0;
      conv_start <= 1'b0;
    end else begin
      rx <= next_rx;
      tx <= next_tx;
      cnt <= next_cnt;
      dac_reg <= next_dac_reg;
      ctrl_reg <= next_ctrl_reg;
      fce <= next_fce;
      comm <= next_comm;
      over <= next_over;
      under <= next_under;
      alert <= next_alert;
      wdt_cnt <= next_wdt_cnt;
      loop_code <= next_loop_code;
      alarm_active <= next_alarm_active;
      conv_start <= next_conv_start;
    end
  end
endmodule : daf_dev

// [tb/daf_assertions.sv]
// link timing and framing assertions for the fault-alert serial link
module daf_assertions (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic sclk,
  input wire logic sync_n,
  input wire logic sdi,
  input wire logic sdo,
  input wire logic fault_alert
);
  timeunit 1ns;
  timeprecision 1ps;
  logic prev_sclk;
  logic next_prev_sclk;
  logic [5:0] rises;
  logic [5:0] next_rises;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  // rising sclk edges in the current frame
  always_comb begin
    next_prev_sclk = sclk;
    next_rises = sync_n ? 6'h00 : rises + {5'h00, sclk & ~prev_sclk};
  end
  always_ff @(posedge ref_clk) begin
    prev_sclk <= next_prev_sclk;
    rises <= next_rises;
  end
  sequence low_rise;
    !sclk [*8] ##1 sclk;
  endsequence
  a_sclk_idle_low: assert property (sync_n |-> !sclk) else $error("sclk high outside frame");
  a_sdi_held: assert property (sclk |-> $stable(sdi)) else $error("sdi moved while sclk high");
  a_sclk_high_span: assert property ($rose(sclk) |-> sclk [*8] ##1 !sclk) else $error("sclk high span");
  a_sclk_low_span: assert property ($fell(sclk) && !sync_n |-> low_rise) else $error("sclk low span");
  a_first_rise: assert property ($fell(sync_n) |-> low_rise) else $error("first sclk rise");
  a_frame_bits: assert property ($rose(sync_n) |-> rises == 6'h18 || rises == 6'h20) else $error("bit count");
  a_sdo_steady: assert property ($rose(sclk) && !sync_n |-> $stable(sdo) [*8]) else $error("sdo moved");
  a_frame_gap: assert property ($rose(sync_n) |-> sync_n [*8]) else $error("frame gap short");
endmodule : daf_assertions

// [tb/dac_fault_alert_and_frame_check_bench.sv]
// bench: host and device ends, a bit-banged second device, axi tasks
module dac_fault_alert_and_frame_check_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk, rst_n, alarm_up;
  logic awvalid, wvalid, bready, arvalid, rready;
  logic [3:0] awaddr, araddr;
  logic [31:0] wdata, rdata, s;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp, r;
  logic [15:0] meas_code, loop_code, loop2;
  logic [7:0] adc_code;
  logic alarm_active, alarm2, conv_start;
  int mismatches, checked, convs;
  daf_link_if link();
  daf_link_if link2();
  daf_host daf_host_i (.ref_clk(ref_clk), .rst_n(rst_n), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_awaddr(awaddr), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hF), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_bresp(bresp),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_araddr(araddr), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .link(link));
  daf_dev #(.WDT_UNIT(100)) daf_dev_i (.ref_clk(ref_clk), .rst_n(rst_n), .link(link), .alarm_up(alarm_up),
    .meas_code(meas_code), .adc_code(adc_code), .loop_code(loop_code), .alarm_active(alarm_active),
    .conv_start(conv_start));
  daf_dev #(.WDT_UNIT(100)) daf_dev_probe_i (.ref_clk(ref_clk), .rst_n(rst_n), .link(link2),
    .alarm_up(alarm_up), .meas_code(loop2), .adc_code(8'h00), .loop_code(loop2), .alarm_active(alarm2),
    .conv_start());
  daf_assertions daf_assertions_i (.ref_clk(ref_clk), .rst_n(rst_n), .sclk(link.sclk), .sync_n(link.sync_n),
    .sdi(link.sdi), .sdo(link.sdo), .fault_alert(link.fault_alert));
  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    if (conv_start === 1'b1) begin
      convs <= convs + 1;
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic final_report();
    if (mismatches == 0 && checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : final_report
  // msb first, zero start, polynomial 0x07
  function automatic logic [7:0] crc(input logic [23:0] d);
    logic [7:0] c;
    c = 8'h00;
    for (int i = 23; i >= 0; i--) begin
      c = {c[6:0], 1'b0} ^ ((c[7] ^ d[i]) ? 8'h07 : 8'h00);
    end
    return c;
  endfunction : crc
  task automatic axi_rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] rs);
    logic ar, done;
    ar = 0;
    done = 0;
    @(posedge ref_clk);
    arvalid <= 1'b1;
    araddr <= a;
    rready <= 1'b1;
    while (!done) begin
      @(posedge ref_clk);
      if (!ar && arready) begin
        ar = 1;
        arvalid <= 1'b0;
      end
      if (ar && rvalid) begin
        done = 1;
        d = rdata;
        rs = rresp;
        rready <= 1'b0;
      end
    end
  endtask : axi_rd
  // frame through the host, long unless lg is 0, then wait until it is no longer busy
  task automatic hframe(input logic [7:0] c, input logic [15:0] d, input logic lg = 1'b1);
    logic aw, w, b;
    aw = 0;
    w = 0;
    b = 0;
    @(posedge ref_clk);
    awvalid <= 1'b1;
    awaddr <= daf_pkg::HREG_CMD;
    wvalid <= 1'b1;
    wdata <= {lg, 7'h00, c, d};
    bready <= 1'b1;
    while (!b) begin
      @(posedge ref_clk);
      if (!aw && awready) begin
        aw = 1;
        awvalid <= 1'b0;
      end
      if (!w && wready) begin
        w = 1;
        wvalid <= 1'b0;
      end
      if (aw && w && bvalid) begin
        b = 1;
        bready <= 1'b0;
        chk(32'(bresp), 32'(daf_pkg::RESP_OKAY));
      end
    end
    s = 32'h0000_0001;
    while (s[0]) begin
      axi_rd(daf_pkg::HREG_STATUS, s, r);
    end
    repeat (8) @(posedge ref_clk);
  endtask : hframe
  // 32-bit frame on the second link, check byte xored with x
  task automatic bang(input logic [23:0] f, input logic [7:0] x);
    logic [31:0] w;
    w = {f, crc(f) ^ x};
    @(posedge ref_clk);
    link2.sync_n <= 1'b0;
    link2.sdi <= w[31];
    for (int i = 0; i < 32; i++) begin
      repeat (4) @(posedge ref_clk);
      link2.sclk <= 1'b1;
      repeat (4) @(posedge ref_clk);
      link2.sclk <= 1'b0;
      link2.sdi <= w[30];
      w = {w[30:0], ~w[31]};
    end
    link2.sync_n <= 1'b1;
    repeat (20) @(posedge ref_clk);
  endtask : bang
  initial begin
    repeat (40000) @(posedge ref_clk);
    mismatches++;
    final_report();
  end
  initial begin
    rst_n = 1'b0;
    alarm_up = 1'b1;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    {awaddr, araddr, wdata} = 40'h00_0000_0000;
    {meas_code, adc_code} = 24'h00_0000;
    {link2.sclk, link2.sync_n, link2.sdi} = 3'h2;
    {mismatches, checked} = 64'h0000_0000_0000_0000;
    repeat (20) @(posedge ref_clk);
    rst_n <= 1'b1;
    repeat (90) @(posedge ref_clk);
    chk(32'(alarm_active), 0);
    repeat (30) @(posedge ref_clk);
    chk(32'(alarm_active), 1);
    chk(32'(loop_code), 32'h0000_FFFF);
    chk(32'(link.fault_alert), 1);
    axi_rd(daf_pkg::HREG_STATUS, s, r);
    chk(32'(s[1]), 1);
    alarm_up <= 1'b0;
    repeat (6) @(posedge ref_clk);
    chk(32'(loop_code), 32'h0000_0000);
    bang({8'h02, 16'h0000}, 8'h00);
    chk(32'(alarm2), 0);
    chk(32'(link2.fault_alert), 0);
    bang({8'h01, 16'hBEEF}, 8'h01);
    chk(32'(loop2), 32'h0000_0000);
    chk(32'(link2.fault_alert), 1);
    bang({8'h85, 16'h0000}, 8'h00);
    chk(32'(link2.fault_alert), 0);
    hframe(8'h02, 16'h0000);
    chk(32'(alarm_active), 0);
    hframe(8'h01, 16'h4321, 1'b0);
    chk(32'(loop_code), 32'h0000_4321);
    hframe(8'h01, 16'h1234);
    chk(32'(loop_code), 32'h0000_1234);
    meas_code <= 16'h1234;
    adc_code <= 8'h3C;
    hframe(8'h08, 16'h0000);
    chk(convs, 1);
    adc_code <= 8'hA5;
    hframe(8'h85, 16'h0000);
    hframe(8'h85, 16'h0000);
    axi_rd(daf_pkg::HREG_RX, s, r);
    chk({8'h00, s[23:0]}, 32'h0085_00A5);
    axi_rd(daf_pkg::HREG_STATUS, s, r);
    chk(32'(s[2]), 1);
    for (int k = 0; k < 2; k++) begin
      meas_code <= k ? 16'h122D : 16'h123B;
      repeat (4) @(posedge ref_clk);
      chk(32'(link.fault_alert), 1);
      hframe(8'h85, 16'h0000);
      hframe(8'h85, 16'h0000);
      axi_rd(daf_pkg::HREG_RX, s, r);
      chk({8'h00, s[23:0]}, k ? 32'h0085_10A5 : 32'h0085_20A5);
    end
    meas_code <= 16'h123A;
    repeat (4) @(posedge ref_clk);
    chk(32'(link.fault_alert), 0);
    axi_rd(4'hC, s, r);
    chk(32'(r), 32'(daf_pkg::RESP_DECERR));
    final_report();
  end
endmodule : dac_fault_alert_and_frame_check_bench
